// ===== design/rbac_bit_packer.sv
`timescale 1ns/100ps
module rbac_bit_packer
  import rbac_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control.
  input  wire logic       start,
  input  wire logic [2:0] align,
  input  wire logic       bit_valid,
  input  wire logic       bit_val,
  input  wire logic       flush,
  // Results.
  output rbac_byte_s      byte_out,
  output logic [2:0]      next_pos
);

  logic [7:0] acc_r;
  logic [2:0] pos_r;
  logic       pend_r;
  rbac_byte_s byte_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Each bit goes into the next higher position; position 7 closes the byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= 8'h00;
      pos_r  <= 3'h0;
      pend_r <= 1'b0;
    end else if (start) begin
      acc_r  <= 8'h00;
      pos_r  <= align; // RL2
      pend_r <= 1'b0;
    end else if (bit_valid) begin
      if (pos_r == 3'h7) begin
        acc_r  <= 8'h00;
        pend_r <= 1'b0;
      end else begin
        acc_r[pos_r] <= bit_val;
        pend_r       <= 1'b1;
      end
      pos_r <= pos_r + 3'h1; // RL3
    end else if (flush) begin
      acc_r  <= 8'h00;
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_r <= '0;
    end else begin
      byte_r.valid <= 1'b0;
      byte_r.last  <= 1'b0;
      if (!start && bit_valid && pos_r == 3'h7) begin
        byte_r.valid <= 1'b1;
        byte_r.data  <= {bit_val, acc_r[6:0]}; // RL3
      end else if (!start && !bit_valid && flush && pend_r) begin
        byte_r.valid <= 1'b1;
        byte_r.data  <= acc_r;
        byte_r.last  <= 1'b1;
      end
    end
  end

  assign byte_out = byte_r;
  assign next_pos = pos_r;

endmodule

// ===== design/rbac_pkg.sv
package rbac_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_CTRL     = 8'h0C;
  localparam logic [7:0] IDX_COLL     = 8'h0D;
  localparam logic [7:0] IDX_ERROR    = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;

  ////////////////////////////////////////////////////////////////////////////////
  // Framing control field positions and reset value.
  localparam int         CTRL_KEEP_BIT   = 7;
  localparam int         CTRL_ALIGN_LSB  = 4;
  localparam int         CTRL_COLLISION_AS_INTEGRITY_ERROR_BIT = 3;
  localparam int         CTRL_LAST_LSB   = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  // Collision position register layout.
  localparam int         COLL_VALID_BIT = 7;
  localparam logic [7:0] COLL_RESET     = 8'h00;
  localparam logic [7:0] COLL_POS_LIMIT = 8'h40;

  // Error register layout.
  localparam int ERR_INTEG_BIT = 0;
  localparam int ERR_COLL_BIT  = 2;

  // Interrupt status and mask layout.
  localparam int         IRQ_FRAME_BIT = 0;
  localparam int         IRQ_COLL_BIT  = 1;
  localparam int         IRQ_INTEG_BIT = 2;
  localparam int         IRQ_BYTE_BIT  = 3;
  localparam logic [3:0] IRQ_RESET     = 4'h0;

  // Saturation value of the received data bit counter.
  localparam logic [7:0] BITCNT_MAX = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive sequencing, Gray coded along idle, receiving, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_DONE = 2'b11
  } rbac_state_e;

  // Indications from the receive decoder, same clock domain.
  typedef struct packed {
    logic start;
    logic bit_valid;
    logic bit_val;
    logic bit_coll;
    logic eof_coll;
    logic integ_err;
    logic frame_end;
  } rbac_dec_s;

  // Stored byte towards the receive data sink.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } rbac_byte_s;

endpackage

// ===== design/rbac_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - Without keep control, zero bits after collision.
// RL2 - First bit lands at programmed position, then upward.
// RL3 - Position seven: second bit starts next byte.
// RL4 - Position zero byte oriented, otherwise bit oriented.
// RL5 - Collision-as-error control makes collisions integrity errors.
// RL6 - Last byte valid bits; zero means full.
// RL7 - Valid bits loaded at end, cleared at start.
// RL8 - Position valid only for reportable collisions.
// RL9 - Position counts data bits of first collision.
// RL10 - Only first sixty-four bit positions reported.
// RL11 - Start position offset added to collision position.
// RL12 - Software trusts position only when valid set.
// RL13 - Collision sets detected flag and records position.
// RL14 - Collision inside end symbol is ignored.
// RL15 - Detected flag cleared when reception starts.
// RL16 - Integrity error sets flag, reception continues.
// RL17 - Position and valid cleared at reception start.
module rbac_top
  import rbac_pkg::*;
(
  // APB clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive decoder.
  input  rbac_dec_s        dec_in,
  // Stored bytes and frame completion.
  output rbac_byte_s       rx_byte,
  output logic             rx_frame_done,
  // Interrupt.
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode helpers.
  function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
    addr_is = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic [7:0] coll_index(input logic [2:0] offs, input logic [7:0] cnt);
    logic [8:0] sum;
    sum = {1'b0, cnt} + {6'h00, offs};
    coll_index = (sum[8] == 1'b1) ? BITCNT_MAX : sum[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic                 keep_r;
  logic [2:0]           align_r;
  logic                 collision_as_integrity_error_r;
  logic [2:0]           last_bits_r;
  logic                 pos_valid_r;
  logic [6:0]           coll_pos_r;
  logic                 coll_det_r;
  logic                 integ_r;
  logic [3:0]           irq_stat_r;
  logic [3:0]           irq_mask_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic [7:0]           bitcnt_r;
  logic                 coll_seen_r;
  logic                 frame_done_r;
  rbac_state_e          state_r;
  rbac_state_e          state_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic       access;
  logic       wr_en;
  logic       wr_byte0;
  logic       hit_ctrl;
  logic       hit_coll;
  logic       hit_err;
  logic       hit_stat;
  logic       hit_mask;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_mask;
  logic       mapped;
  logic [7:0] rd_value;

  assign access   = psel && penable;
  assign wr_en    = access && pready_r && pwrite && !pslverr_r;
  assign wr_byte0 = wr_en && pstrb[0];
  assign hit_ctrl = addr_is(paddr, IDX_CTRL);
  assign hit_coll = addr_is(paddr, IDX_COLL);
  assign hit_err  = addr_is(paddr, IDX_ERROR);
  assign hit_stat = addr_is(paddr, IDX_IRQ_STAT);
  assign hit_mask = addr_is(paddr, IDX_IRQ_MASK);
  assign mapped   = hit_ctrl || hit_coll || hit_err || hit_stat || hit_mask;

  // Only the low byte lane carries register bits; other lanes are ignored.
  assign wr_ctrl  = wr_byte0 && hit_ctrl;
  assign wr_stat  = wr_byte0 && hit_stat;
  assign wr_mask  = wr_byte0 && hit_mask;

  always_comb begin
    rd_value = 8'h00;
    if (hit_ctrl) begin
      rd_value = {keep_r, align_r, collision_as_integrity_error_r, last_bits_r};
    end else if (hit_coll) begin
      rd_value = {pos_valid_r, coll_pos_r};
    end else if (hit_err) begin
      rd_value[ERR_INTEG_BIT] = integ_r;
      rd_value[ERR_COLL_BIT]  = coll_det_r;
    end else if (hit_stat) begin
      rd_value = {4'h0, irq_stat_r};
    end else if (hit_mask) begin
      rd_value = {4'h0, irq_mask_r};
    end
  end

  // One wait state: data and error flag are registered on the edge where pready rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (access && !pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r  <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_value};
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive sequencing.
  logic bit_take;
  logic end_take;
  logic bit_stored;
  logic coll_now;
  logic coll_first;

  assign bit_take   = (state_r == ST_RECV) && dec_in.bit_valid && !dec_in.start;
  assign end_take   = (state_r == ST_RECV) && dec_in.frame_end && !dec_in.start;
  assign coll_now   = bit_take && dec_in.bit_coll;
  assign coll_first = coll_now && !coll_seen_r;
  // The colliding bit keeps its value; only the bits after it are forced to zero.
  assign bit_stored = (coll_seen_r && !keep_r) ? 1'b0 : dec_in.bit_val; // RL1

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (dec_in.start) begin
          state_nxt = ST_RECV;
        end
      end
      ST_RECV: begin
        if (dec_in.start) begin
          state_nxt = ST_RECV;
        end else if (dec_in.frame_end) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = dec_in.start ? ST_RECV : ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Data bit counter and first-collision marker; framing symbols never count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt_r    <= 8'h00;
      coll_seen_r <= 1'b0;
    end else if (dec_in.start) begin
      bitcnt_r    <= 8'h00;
      coll_seen_r <= 1'b0;
    end else if (bit_take) begin
      if (bitcnt_r != BITCNT_MAX) begin
        bitcnt_r <= bitcnt_r + 8'h01; // RL9
      end
      if (dec_in.bit_coll) begin
        coll_seen_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit packing into stored bytes; a bit alongside a new start is dropped.
  logic [2:0] next_pos;

  rbac_bit_packer u_packer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (dec_in.start),
    .align     (align_r),
    .bit_valid (bit_take),
    .bit_val   (bit_stored),
    .flush     (end_take),
    .byte_out  (rx_byte),
    .next_pos  (next_pos)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Framing control register; the valid-bits field is also loaded by hardware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_r   <= CTRL_RESET[CTRL_KEEP_BIT];
      align_r  <= CTRL_RESET[CTRL_ALIGN_LSB +: 3];
      collision_as_integrity_error_r <= CTRL_RESET[CTRL_COLLISION_AS_INTEGRITY_ERROR_BIT];
    end else if (wr_ctrl) begin
      keep_r   <= pwdata[CTRL_KEEP_BIT];
      align_r  <= pwdata[CTRL_ALIGN_LSB +: 3];
      collision_as_integrity_error_r <= pwdata[CTRL_COLLISION_AS_INTEGRITY_ERROR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_bits_r <= CTRL_RESET[CTRL_LAST_LSB +: 3];
    end else if (dec_in.start) begin
      last_bits_r <= 3'h0; // RL7
    end else if (end_take) begin
      last_bits_r <= (align_r != 3'h0) ? next_pos : 3'h0; // RL4 RL6 RL7
    end else if (wr_ctrl) begin
      last_bits_r <= pwdata[CTRL_LAST_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First collision position.
  logic [7:0] coll_idx;

  assign coll_idx = coll_index(align_r, bitcnt_r); // RL11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_valid_r <= COLL_RESET[COLL_VALID_BIT];
      coll_pos_r  <= COLL_RESET[6:0];
    end else if (dec_in.start) begin
      pos_valid_r <= 1'b0; // RL17
      coll_pos_r  <= 7'h00; // RL17
    end else if (coll_first) begin
      if (coll_idx < COLL_POS_LIMIT) begin
        pos_valid_r <= 1'b1; // RL8 RL10
        coll_pos_r  <= coll_idx[6:0]; // RL13
      end else begin
        pos_valid_r <= 1'b0; // RL8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error flags; an end-symbol collision is ignored and never stops reception.
  logic integ_evt;

  assign integ_evt = (state_r == ST_RECV) && !dec_in.start &&
                     (dec_in.integ_err || (collision_as_integrity_error_r && dec_in.bit_valid && dec_in.bit_coll));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_det_r <= 1'b0;
    end else if (coll_now) begin
      coll_det_r <= 1'b1; // RL13 RL14
    end else if (dec_in.start) begin
      coll_det_r <= 1'b0; // RL15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_r <= 1'b0;
    end else if (integ_evt) begin
      integ_r <= 1'b1; // RL5 RL16
    end else if (dec_in.start) begin
      integ_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event wins over the clear.
  logic [3:0] irq_evt;

  assign irq_evt[IRQ_FRAME_BIT] = end_take;
  assign irq_evt[IRQ_COLL_BIT]  = coll_now;
  assign irq_evt[IRQ_INTEG_BIT] = integ_evt;
  assign irq_evt[IRQ_BYTE_BIT]  = rx_byte.valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= IRQ_RESET;
    end else if (wr_stat) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_r <= pwdata[3:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame completion pulse, one cycle after the decoder's end indication.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_done_r <= 1'b0;
    end else begin
      frame_done_r <= end_take;
    end
  end

  assign rx_frame_done = frame_done_r;

endmodule

// ===== verification/rbac_dec_model.sv
`timescale 1ns/100ps
module rbac_dec_model
  import rbac_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Decoder indications.
  output rbac_dec_s dec
);
  initial dec = '0;

  // Drives one cycle; an idle data line shows the inverse of its last value.
  task put(input rbac_dec_s d);
    @(posedge pclk);
    if (!d.bit_valid) d.bit_val = ~dec.bit_val;
    dec <= d;
  endtask
  task start_rx;
    put('{start: 1'b1, default: 1'b0});
  endtask
  task data_bit(input logic v, input logic c, input int gap);
    put('{1'b0, 1'b1, v, c, 1'b0, 1'b0, 1'b0});
    repeat (gap) put('0);
  endtask
  task eof_pulse;
    put('{eof_coll: 1'b1, default: 1'b0});
  endtask
  task integ_pulse;
    put('{integ_err: 1'b1, default: 1'b0});
  endtask
  task end_rx;
    put('{frame_end: 1'b1, default: 1'b0});
    put('0);
  endtask
endmodule

// ===== verification/rbac_monitor.sv
`timescale 1ns/100ps
module rbac_monitor
  import rbac_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Decoder and results.
  input rbac_dec_s        dec_in,
  input rbac_byte_s       rx_byte,
  input wire logic        rx_frame_done,
  input wire logic        irq
);
  logic [2:0] align_r;
  logic       apb_wr;
  logic       evt;
  assign apb_wr = psel && penable && pready && pwrite;
  assign evt = apb_wr || dec_in.bit_valid || dec_in.integ_err || dec_in.frame_end;

  // Follows the first-bit position that software programs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      align_r <= 3'h0;
    end else if (apb_wr && pstrb[0] && paddr == 12'h030) begin
      align_r <= pwdata[6:4];
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_first_bit(logic hit);
    hit && dec_in.start ##1 dec_in.bit_valid;
  endsequence

  property p_wait_state;
    s_setup |-> !pready ##1 pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  property p_done;
    rx_frame_done |-> $past(dec_in.frame_end);
  endproperty
  property p_last;
    rx_byte.valid && rx_byte.last |-> rx_frame_done;
  endproperty
  property p_byte_cause;
    rx_byte.valid |-> $past(dec_in.bit_valid) || $past(dec_in.frame_end);
  endproperty
  property p_align7;
    s_first_bit(align_r == 3'h7) |=> rx_byte.valid;
  endproperty
  property p_align0;
    s_first_bit(align_r == 3'h0) |=> !rx_byte.valid;
  endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(evt) || $past(evt, 2);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(apb_wr);
  endproperty

  ////////////////////////////////////////
  a_wait_state: assert property (p_wait_state)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr outside answer cycle");
  a_done: assert property (p_done)
    else $error("frame done without frame end");
  a_last: assert property (p_last)
    else $error("last byte not with frame done");
  a_byte_cause: assert property (p_byte_cause)
    else $error("byte stored without cause");
  a_align7: assert property (p_align7)
    else $error("position seven did not close byte");
  a_align0: assert property (p_align0)
    else $error("byte mode stored early");
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without event");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without write");
endmodule

bind rbac_top rbac_monitor mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dec_in(dec_in), .rx_byte(rx_byte),
  .rx_frame_done(rx_frame_done), .irq(irq)
);

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rbac_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, rx_frame_done, irq;
  rbac_dec_s   dec;
  rbac_byte_s  rx_byte;
  int          n_errors, tests_run, n_done, n_frm;
  logic [8:0]  by_q[$];
  logic [16:0] rd_q[$];
  logic [8:0]  eb;
  logic [16:0] er;

  rbac_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dec_in(dec), .rx_byte(rx_byte),
    .rx_frame_done(rx_frame_done), .irq(irq)
  );
  rbac_dec_model mdl_u (.pclk(pclk), .dec(dec));

  always #5 pclk = ~pclk;

  task check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task conclude;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////
  // Compares each stored byte and read answer with the oldest note.
  always @(posedge pclk) begin
    if (rx_byte.valid === 1'b1) begin
      eb = by_q.pop_front();
      check("byte", {rx_byte.data, rx_byte.last}, eb);
    end
    if (rx_frame_done === 1'b1) n_done++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      er = rd_q.pop_front();
      check("reg", {pslverr, prdata[7:0]} & {1'b1, er[16:9]}, er[8:0]);
    end
  end

  task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [7:0] m, input logic [8:0] e);
    rd_q.push_back({m, e});
    apb(a, 1'b0, 8'h00);
  endtask

  task frame(input logic [2:0] al, input logic keep, input logic nc, input int n,
             input int ci, input int ie);
    logic [7:0] acc;
    logic [2:0] pos;
    logic       v;
    logic       z;
    logic       hit;
    int         cp;
    apb(12'h030, 1'b1, {keep, al, nc, 3'h0});
    acc = 8'h00;
    pos = al;
    z = 1'b0;
    hit = ci < n;
    cp = ci + al;
    n_frm++;
    mdl_u.start_rx();
    for (int i = 0; i < n; i++) begin
      v = 1'($urandom);
      acc[pos] = v & ~z;
      if (i == ci && !keep) z = 1'b1;
      mdl_u.data_bit(v, i == ci || i == ci + 5, $urandom_range(2, 0));
      if (i == ie) mdl_u.integ_pulse();
      if (pos == 3'h7) begin
        by_q.push_back({acc, 1'b0});
        acc = 8'h00;
      end
      pos++;
    end
    if (pos != 3'h0) by_q.push_back({acc, 1'b1});
    mdl_u.eof_pulse();
    mdl_u.end_rx();
    mdl_u.data_bit(1'b1, 1'b1, 3);
    rd(12'h030, 8'hFF, {1'b0, keep, al, nc, al == 3'h0 ? 3'h0 : pos});
    rd(12'h034, hit && cp > 63 ? 8'h80 : 8'hFF, hit && cp < 64 ? 9'(cp + 128) : 9'h0);
    rd(12'h080, 8'h05, {6'h0, hit, 1'b0, (hit && nc) || ie < n});
  endtask

  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    void'($urandom(99268));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h030, 8'hFF, 9'h000);
    rd(12'h034, 8'hFF, 9'h000);
    rd(12'h084, 8'hFF, 9'h000);
    rd(12'h03C, 8'hFF, 9'h100);
    rd(12'h031, 8'hFF, 9'h100);
    apb(12'h088, 1'b1, 8'h02);
    frame(3'h7, 1'b0, 1'b0, 2, 99, 99);
    check("irq", {8'h0, irq}, 9'h000);
    frame(3'h4, 1'b0, 1'b0, 8, 3, 99);
    check("irq", {8'h0, irq}, 9'h001);
    apb(12'h084, 1'b1, 8'h02);
    @(negedge pclk);
    check("irq", {8'h0, irq}, 9'h000);
    apb(12'h088, 1'b1, 8'h01);
    @(negedge pclk);
    check("irq", {8'h0, irq}, 9'h001);
    apb(12'h084, 1'b1, 8'h0F);
    rd(12'h084, 8'hFF, 9'h000);
    frame(3'h0, 1'b1, 1'b1, 72, 63, 99);
    frame(3'h1, 1'b0, 1'b0, 70, 63, 20);
    frame(3'h0, 1'b0, 1'b0, 16, 99, 99);
    frame(3'h0, 1'b0, 1'b0, 8, 0, 99);
    frame(3'h0, 1'b0, 1'b0, 16, 8, 99);
    for (int a = 1; a < 7; a++) frame(3'(a), 1'b1, 1'b0, 5 + a, a, 99);
    repeat (2) @(posedge pclk);
    check("pending", 9'(by_q.size() + rd_q.size()), 9'h000);
    check("frames", 9'(n_done), 9'(n_frm));
    conclude();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    conclude();
  end
endmodule
